/* hdl/sass_cfg.svh */
// timing and width constants for the strobe sequenced converter control
// assumes a 20 MHz system clock; included by the core and top modules, not by the package
`ifndef SASS_CFG_SVH
`define SASS_CFG_SVH

`define SASS_RES_BITS      12
`define SASS_IDX_W         4
`define SASS_CNT_W         7
`define SASS_SYS_MHZ       20
`define SASS_PWRUP_NS      1000
`define SASS_ACQ_MIN_NS    1400
`define SASS_CONV_MAX_NS   3700
`define SASS_PWRUP_CYC     ((`SASS_PWRUP_NS * `SASS_SYS_MHZ + 999) / 1000)
`define SASS_CONV_MAX_CYC  ((`SASS_CONV_MAX_NS * `SASS_SYS_MHZ) / 1000)
`define SASS_BIT_CYC       5
`define SASS_LAST_BIT      4'hb

`endif

/* hdl/sass_pkg.sv */
// types shared by the sequencer and its approximation core
// assumes sass_cfg.svh for the numeric constants
`default_nettype none
package sass_pkg;

   typedef enum logic [4:0]
   {
      SEQ_IDLE  = 5'h01,
      SEQ_TRACK = 5'h02,
      SEQ_GAP   = 5'h04,
      SEQ_CONV  = 5'h08,
      SEQ_READ  = 5'h10
   } sass_seq_t;

   typedef enum logic [1:0]
   {
      CORE_IDLE  = 2'h1,
      CORE_TRIAL = 2'h2
   } sass_core_t;

endpackage : sass_pkg
`default_nettype wire

/* hdl/sass_sar_core.sv */
// successive approximation core: one trial bit per fixed group of cycles
// assumes a start pulse on clk_sys and an asynchronous comparator level
`timescale 1ns/1ns
`default_nettype none
`include "sass_cfg.svh"

module sass_sar_core
   import sass_pkg::*;
#(
   parameter int BITS    = `SASS_RES_BITS,
   parameter int BIT_CYC = `SASS_BIT_CYC
)
(
   input  wire logic            clk_sys,
   input  wire logic            resetn,
   input  wire logic            startConv,
   input  wire logic            compIn,
   output logic [BITS-1:0]      dacCode,
   output logic                 convDone
);

   localparam int IW = $clog2(BITS);
   localparam int CW = $clog2(BIT_CYC + 1);

   sass_core_t       state_reg, state_next;
   logic [IW-1:0]    bitIdx_reg, bitIdx_next;
   logic [CW-1:0]    cyc_reg, cyc_next;
   logic [BITS-1:0]  code_reg, code_next;
   logic             done_reg, done_next;
   logic             compMeta_reg;
   logic             compSync_reg;

   function automatic logic [BITS-1:0] bitMask(input logic [IW-1:0] idx);
      bitMask = {{(BITS-1){1'b0}}, 1'b1} << idx;
   endfunction : bitMask

   always_comb
   begin
      state_next  = state_reg;
      bitIdx_next = bitIdx_reg;
      cyc_next    = cyc_reg;
      code_next   = code_reg;
      done_next   = 1'b0;
      unique case (state_reg)
         CORE_IDLE:
         begin
            if (startConv)
            begin
               bitIdx_next = IW'(BITS - 1);
               cyc_next    = '0;
               code_next   = bitMask(IW'(BITS - 1));
               state_next  = CORE_TRIAL;
            end
         end
         CORE_TRIAL:
         begin
            // settle time covers the two synchroniser stages of the comparator
            if (cyc_reg == CW'(BIT_CYC - 1))
            begin
               cyc_next = '0;
               if (!compSync_reg)
                  code_next = code_reg & ~bitMask(bitIdx_reg);
               if (bitIdx_reg == '0)
               begin
                  done_next  = 1'b1;
                  state_next = CORE_IDLE;
               end
               else
               begin
                  bitIdx_next = bitIdx_reg - IW'(1);
                  code_next   = code_next | bitMask(bitIdx_reg - IW'(1));
               end
            end
            else
               cyc_next = cyc_reg + CW'(1);
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         state_reg    <= CORE_IDLE;
         bitIdx_reg   <= '0;
         cyc_reg      <= '0;
         code_reg     <= '0;
         done_reg     <= 1'b0;
         compMeta_reg <= 1'b0;
         compSync_reg <= 1'b0;
      end
      else
      begin
         state_reg    <= state_next;
         bitIdx_reg   <= bitIdx_next;
         cyc_reg      <= cyc_next;
         code_reg     <= code_next;
         done_reg     <= done_next;
         compMeta_reg <= compIn;
         compSync_reg <= compMeta_reg;
      end
   end

   assign dacCode  = code_reg;
   assign convDone = done_reg;

endmodule : sass_sar_core
`default_nettype wire

/* hdl/sass_top.sv */
// strobe driven sequencer of a 12-bit approximation converter with serial readout
// assumes strobe and serial clock from a host; serial clock may stop between frames
//
// Behaviour
// - strobe rise powers up and starts tracking
// - strobe fall holds and converts the difference
// - MSB on data output within 3.7 us
// - shut down by itself after conversion
// - single pulse after full read selects channel one
// - short readout forces channel two next
// - differential: single unipolar, double or short bipolar
// - unipolar straight binary, bipolar two's complement
// - result MSB first, changes on falling clock
// - strobe rise drives data output low
// - data output released after last bit
`timescale 1ns/1ns
`default_nettype none
`include "sass_cfg.svh"

module sass_top
   import sass_pkg::*;
#(
   parameter bit DIFFERENTIAL = 1'b0,
   parameter int BITS         = `SASS_RES_BITS
)
(
   input  wire logic            clk_sys,
   input  wire logic            resetn,
   input  wire logic            convertStrobe,
   input  wire logic            serialClk,
   input  wire logic            compIn,
   output logic                 serialDataOut,
   output logic                 serialDataOe,
   output logic                 powerOn,
   output logic                 trackEn,
   output logic                 inputChannelTwo,
   output logic                 bipolarMode,
   output logic [BITS-1:0]      dacCode
);

   localparam logic [`SASS_CNT_W-1:0] PWRUP_CYC =
      `SASS_CNT_W'(`SASS_PWRUP_CYC);
   localparam logic [`SASS_CNT_W-1:0] CONV_MAX_CYC =
      `SASS_CNT_W'(`SASS_CONV_MAX_CYC);

   // selection pulse and abandoned gap share one limit
   function automatic logic allowanceOver(input logic [`SASS_CNT_W-1:0] cnt);
      allowanceOver = (cnt >= PWRUP_CYC);
   endfunction : allowanceOver

   // system domain state
   sass_seq_t                 state_reg, state_next;
   logic [`SASS_CNT_W-1:0]    cnt_reg, cnt_next;
   logic                      pulseSeen_reg, pulseSeen_next;
   logic                      alt_reg, alt_next;
   logic                      chanTwo_reg, chanTwo_next;
   logic                      bipolar_reg, bipolar_next;
   logic                      power_reg, power_next;
   logic                      track_reg, track_next;
   logic                      start_reg, start_next;
   logic                      oe_reg, oe_next;
   logic                      linkClr_reg, linkClr_next;
   logic                      fullRead_reg, fullRead_next;
   logic [BITS-1:0]           result_reg, result_next;

   // synchronisers into the system domain
   logic                      strobeMeta_reg;
   logic                      strobeSync_reg;
   logic                      strobeLast_reg;
   logic                      doneMeta_reg;
   logic                      doneSync_reg;

   // link domain state
   logic [`SASS_IDX_W-1:0]    bitCnt_reg, bitCnt_next;
   logic                      linkDone_reg, linkDone_next;

   logic                      strobeRise;
   logic                      strobeFall;
   logic                      convDone;
   logic [BITS-1:0]           coreCode;
   logic                      fullNow;

   sass_sar_core #(
      .BITS    (BITS),
      .BIT_CYC (`SASS_BIT_CYC)
   ) u_core (
      .clk_sys   (clk_sys),
      .resetn    (resetn),
      .startConv (start_reg),
      .compIn    (compIn),
      .dacCode   (coreCode),
      .convDone  (convDone)
   );

   // pulses shorter than one system period may be missed entirely
   assign strobeRise = strobeSync_reg & ~strobeLast_reg;
   assign strobeFall = ~strobeSync_reg & strobeLast_reg;

   // readout only counts once a result was offered; after reset treat as read
   assign fullNow = (state_reg == SEQ_READ) ? doneSync_reg : fullRead_reg;

   always_comb
   begin
      state_next     = state_reg;
      cnt_next       = cnt_reg;
      pulseSeen_next = pulseSeen_reg;
      alt_next       = alt_reg;
      chanTwo_next   = chanTwo_reg;
      bipolar_next   = bipolar_reg;
      power_next     = power_reg;
      track_next     = track_reg;
      start_next     = 1'b0;
      oe_next        = oe_reg;
      linkClr_next   = linkClr_reg;
      fullRead_next  = fullRead_reg;
      result_next    = result_reg;
      if (cnt_reg != {`SASS_CNT_W{1'b1}})
         cnt_next = cnt_reg + `SASS_CNT_W'(1);
      unique case (state_reg)
         SEQ_IDLE, SEQ_READ:
         begin
            if (strobeRise)
            begin
               state_next     = SEQ_TRACK;
               power_next     = 1'b1;
               track_next     = 1'b1;
               oe_next        = 1'b1;
               linkClr_next   = 1'b1;
               cnt_next       = '0;
               pulseSeen_next = 1'b0;
               fullRead_next  = fullNow;
               alt_next       = ~fullNow;
            end
         end
         SEQ_TRACK:
         begin
            if (strobeFall)
            begin
               // a fall inside the power-up allowance is a selection pulse
               if (!pulseSeen_reg && !allowanceOver(cnt_reg))
               begin
                  state_next     = SEQ_GAP;
                  pulseSeen_next = 1'b1;
                  cnt_next       = '0;
               end
               else
               begin
                  state_next = SEQ_CONV;
                  track_next = 1'b0;
                  start_next = 1'b1;
                  cnt_next   = '0;
               end
            end
         end
         SEQ_GAP:
         begin
            if (strobeRise)
            begin
               state_next = SEQ_TRACK;
               alt_next   = 1'b1;
               cnt_next   = PWRUP_CYC;
            end
            else if (allowanceOver(cnt_reg))
            begin
               // abandoned selection: power down, nothing to read
               state_next = SEQ_IDLE;
               power_next = 1'b0;
               track_next = 1'b0;
               oe_next    = 1'b0;
            end
         end
         SEQ_CONV:
         begin
            if (convDone)
            begin
               state_next   = SEQ_READ;
               power_next   = 1'b0;
               linkClr_next = 1'b0;
               if (bipolar_reg)
                  result_next = {~coreCode[BITS-1], coreCode[BITS-2:0]};
               else
                  result_next = coreCode;
            end
            else if (cnt_reg >= CONV_MAX_CYC)
            begin
               // never reached with the fixed trial length; a stalled core
               // must not leave the device powered past the deadline
               state_next = SEQ_IDLE;
               power_next = 1'b0;
               oe_next    = 1'b0;
            end
         end
      endcase
      // the selection lines follow the variant; the other one stays low
      chanTwo_next = DIFFERENTIAL ? 1'b0 : alt_next;
      bipolar_next = DIFFERENTIAL ? alt_next : 1'b0;
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         state_reg      <= SEQ_IDLE;
         cnt_reg        <= '0;
         pulseSeen_reg  <= 1'b0;
         alt_reg        <= 1'b0;
         chanTwo_reg    <= 1'b0;
         bipolar_reg    <= 1'b0;
         power_reg      <= 1'b0;
         track_reg      <= 1'b0;
         start_reg      <= 1'b0;
         oe_reg         <= 1'b0;
         linkClr_reg    <= 1'b1;
         fullRead_reg   <= 1'b1;
         result_reg     <= '0;
      end
      else
      begin
         state_reg      <= state_next;
         cnt_reg        <= cnt_next;
         pulseSeen_reg  <= pulseSeen_next;
         alt_reg        <= alt_next;
         chanTwo_reg    <= chanTwo_next;
         bipolar_reg    <= bipolar_next;
         power_reg      <= power_next;
         track_reg      <= track_next;
         start_reg      <= start_next;
         oe_reg         <= oe_next;
         linkClr_reg    <= linkClr_next;
         fullRead_reg   <= fullRead_next;
         result_reg     <= result_next;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         strobeMeta_reg <= 1'b0;
         strobeSync_reg <= 1'b0;
         strobeLast_reg <= 1'b0;
         doneMeta_reg   <= 1'b0;
         doneSync_reg   <= 1'b0;
      end
      else
      begin
         strobeMeta_reg <= convertStrobe;
         strobeSync_reg <= strobeMeta_reg;
         strobeLast_reg <= strobeSync_reg;
         doneMeta_reg   <= linkDone_reg;
         doneSync_reg   <= doneMeta_reg;
      end
   end

   // link domain: the clear comes from a system flop and is held through
   // tracking and conversion, so no serial clock edge is needed to rearm
   always_comb
   begin
      bitCnt_next   = bitCnt_reg;
      linkDone_next = linkDone_reg;
      if (bitCnt_reg != `SASS_LAST_BIT)
         bitCnt_next = bitCnt_reg + `SASS_IDX_W'(1);
      if (bitCnt_reg == `SASS_LAST_BIT)
         linkDone_next = 1'b1;
   end

   always_ff @(negedge serialClk or negedge resetn or posedge linkClr_reg)
   begin
      if (!resetn)
         bitCnt_reg <= '0;
      else if (linkClr_reg)
         bitCnt_reg <= '0;
      else
         bitCnt_reg <= bitCnt_next;
   end

   always_ff @(posedge serialClk or negedge resetn or posedge linkClr_reg)
   begin
      if (!resetn)
         linkDone_reg <= 1'b0;
      else if (linkClr_reg)
         linkDone_reg <= 1'b0;
      else
         linkDone_reg <= linkDone_next;
   end

   // result_reg is stable for the whole frame, so the link may index it
   assign serialDataOut = (state_reg == SEQ_READ) ?
                          result_reg[`SASS_LAST_BIT - bitCnt_reg] : 1'b0;
   assign serialDataOe  = oe_reg & ~linkDone_reg;

   assign powerOn         = power_reg;
   assign trackEn         = track_reg;
   assign inputChannelTwo = chanTwo_reg;
   assign bipolarMode     = bipolar_reg;
   assign dacCode         = coreCode;

endmodule : sass_top
`default_nettype wire

/* verification/sass_monitor.sv */
// concurrent checks on the strobe sequencer ports
// assumes a bind to every sass_top instance; all checks in the clk_sys domain
`timescale 1ns/1ns
`default_nettype none
module sass_monitor
   import sass_pkg::*;
#(
   parameter bit DIFFERENTIAL = 1'b0,
   parameter int BITS         = 12
)
(
   input wire logic            clk_sys,
   input wire logic            resetn,
   input wire logic            convertStrobe,
   input wire logic            serialClk,
   input wire logic            compIn,
   input wire logic            serialDataOut,
   input wire logic            serialDataOe,
   input wire logic            powerOn,
   input wire logic            trackEn,
   input wire logic            inputChannelTwo,
   input wire logic            bipolarMode,
   input wire logic [BITS-1:0] dacCode
);
   // high time of the strobe pin, saturating; tells a conversion from a select pulse
   logic [5:0] hiCnt_reg;
   logic [5:0] hiCnt_next;

   always_comb
   begin
      hiCnt_next = !convertStrobe ? 6'h00 : (&hiCnt_reg ? hiCnt_reg : hiCnt_reg + 6'h01);
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         hiCnt_reg <= 6'h00;
      else
         hiCnt_reg <= hiCnt_next;
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   sequence sConvFall;
      $fell(convertStrobe) && hiCnt_reg >= 6'h18 && trackEn;
   endsequence

   sequence sHeld;
      (!trackEn && powerOn) ##1 (!trackEn) [*8];
   endsequence

   AST_TRACK_POWER: assert property (trackEn |-> powerOn)
      else $error("tracking without power");
   AST_RISE_TRACK: assert property ($rose(convertStrobe) && !powerOn && !serialDataOe
      |-> ##[2:6] (powerOn && trackEn)) else $error("strobe rise did not start tracking");
   AST_POWER_DOUT_LOW: assert property (powerOn |-> serialDataOe && !serialDataOut)
      else $error("data pin not driven low while powered");
   AST_HOLD_ON_FALL: assert property (sConvFall |-> ##[2:5] sHeld)
      else $error("strobe fall did not hold");
   AST_MSB_DEADLINE: assert property (sConvFall |-> ##[1:74] (!powerOn && serialDataOe))
      else $error("conversion not done in time");
   AST_STAYS_OFF: assert property ((!convertStrobe && !powerOn) [*6] |=> !powerOn)
      else $error("woke up without a strobe");
   AST_SEL_STABLE: assert property ($changed(inputChannelTwo) || $changed(bipolarMode)
      |-> powerOn && trackEn) else $error("selection changed outside a strobe rise");
   AST_VARIANT: assert property (DIFFERENTIAL ? !inputChannelTwo : !bipolarMode)
      else $error("selection of the wrong variant");
endmodule : sass_monitor

bind sass_top sass_monitor #(.DIFFERENTIAL(DIFFERENTIAL), .BITS(BITS)) mon (
   .clk_sys(clk_sys), .resetn(resetn), .convertStrobe(convertStrobe),
   .serialClk(serialClk), .compIn(compIn), .serialDataOut(serialDataOut),
   .serialDataOe(serialDataOe), .powerOn(powerOn), .trackEn(trackEn),
   .inputChannelTwo(inputChannelTwo), .bipolarMode(bipolarMode), .dacCode(dacCode));
`default_nettype wire

/* verification/sass_host_model.sv */
// host model: drives strobe and serial clock, reads two converters at once
// assumes clk_sys at 20 MHz; serial clock only runs inside a frame
`timescale 1ns/1ns
`default_nettype none
module sass_host_model
#(
   parameter int SOURCE_OHM = 0
)
(
   input  wire logic clk_sys,
   input  wire logic dataA,
   input  wire logic oeA,
   input  wire logic dataB,
   input  wire logic oeB,
   output var logic  convertStrobe,
   output var logic  serialClk
);
   localparam int ACQ_NS  = 9 * (SOURCE_OHM + 1500) * 20 / 1000 + 1000;
   localparam int ACQ_CYC = ((ACQ_NS < 1400 ? 1400 : ACQ_NS) + 49) / 50;
   // released pin: inverse of last level, so a floating line never reads right
   logic lastA;
   logic lastB;

   initial
   begin
      convertStrobe = 1'b0;
      serialClk     = 1'b0;
      lastA         = 1'b0;
      lastB         = 1'b0;
   end

   task automatic track(input bit alt);
      if (alt)
      begin
         @(posedge clk_sys) convertStrobe <= 1'b1;
         repeat (4) @(posedge clk_sys);
         convertStrobe <= 1'b0;
         repeat (4) @(posedge clk_sys);
      end
      else
         @(posedge clk_sys);
      convertStrobe <= 1'b1;
   endtask : track

   // lone short pulse: with no second rise the selection is abandoned
   task automatic pulse();
      @(posedge clk_sys) convertStrobe <= 1'b1;
      repeat (4) @(posedge clk_sys);
      convertStrobe <= 1'b0;
   endtask : pulse

   task automatic convert();
      repeat (ACQ_CYC) @(posedge clk_sys);
      convertStrobe <= 1'b0;
   endtask : convert

   // samples on rising edges; a short count leaves the word unfinished on purpose
   task automatic read(input int n, output logic [11:0] wA, output logic [11:0] wB);
      wA = 12'h000;
      wB = 12'h000;
      #7;
      for (int i = 0; i < n; i++)
      begin
         #15 serialClk = 1'b1;
         lastA = oeA ? dataA : ~lastA;
         lastB = oeB ? dataB : ~lastB;
         wA = {wA[10:0], lastA};
         wB = {wB[10:0], lastB};
         #15 serialClk = 1'b0;
      end
   endtask : read
endmodule : sass_host_model
`default_nettype wire

/* verification/sar_adc_strobe_sequencer_bench.sv */
// self-checking bench: single-ended and differential sequencers side by side
// assumes the host model on strobe and serial clock; comparator modelled here
`timescale 1ns/1ns
`default_nettype none
module sar_adc_strobe_sequencer_bench;
   logic        clk_sys = 1'b0;
   logic        resetn;
   logic [11:0] vin;
   logic [1:0]  comp;
   logic [11:0] w [2];
   wire logic   [1:0] dout, oe, pwr, trk, ch2, bip;
   wire logic   [11:0] dacA, dacB;
   wire logic   strobe;
   wire logic   sclk;
   int          fail_count, compares, t, j, seed, code [2];
   int          expQ [$];
   bit          selAlt, fullRead;
   bit          altTab [8] = '{0, 1, 0, 0, 1, 0, 0, 1};
   int          lenTab [8] = '{12, 12, 8, 12, 5, 12, 12, 12};

   sass_top #(.DIFFERENTIAL(1'b0)) uut (.clk_sys(clk_sys), .resetn(resetn),
      .convertStrobe(strobe), .serialClk(sclk), .compIn(comp[0]), .serialDataOut(dout[0]),
      .serialDataOe(oe[0]), .powerOn(pwr[0]), .trackEn(trk[0]), .inputChannelTwo(ch2[0]),
      .bipolarMode(bip[0]), .dacCode(dacA));
   sass_top #(.DIFFERENTIAL(1'b1)) uutDiff (.clk_sys(clk_sys), .resetn(resetn),
      .convertStrobe(strobe), .serialClk(sclk), .compIn(comp[1]), .serialDataOut(dout[1]),
      .serialDataOe(oe[1]), .powerOn(pwr[1]), .trackEn(trk[1]), .inputChannelTwo(ch2[1]),
      .bipolarMode(bip[1]), .dacCode(dacB));
   sass_host_model host (.clk_sys(clk_sys), .dataA(dout[0]), .oeA(oe[0]), .dataB(dout[1]),
      .oeB(oe[1]), .convertStrobe(strobe), .serialClk(sclk));

   always #25 clk_sys = ~clk_sys;

   // comparator: high while the input is at or above the trial code
   always @(posedge clk_sys)
   begin
      comp[0] <= (vin >= dacA);
      comp[1] <= (vin >= dacB);
   end

   task automatic check_bit(input string what, input logic exp, input logic got);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH %s expected %0b seen %0b", what, exp, got);
      end
   endtask : check_bit

   task automatic check_word(input string what, input logic [11:0] exp, input logic [11:0] got);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check_word

   task automatic test_done();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done

   initial
   begin
      #2000000;
      fail_count++;
      test_done();
   end

   initial
   begin
      resetn   = 1'b0;
      vin      = 12'h000;
      seed     = 32'h1871f370;
      fullRead = 1'b1;
      repeat (6) @(posedge clk_sys);
      check_bit("reset powerOn", 1'b0, pwr[0] | pwr[1]);
      check_bit("reset oe", 1'b0, oe[0] | oe[1]);
      resetn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      for (t = 0; t < 8; t++)
      begin
         code[0] = (t == 0) ? 0 : (t == 1) ? 4095 : ($random(seed) & 32'hfff);
         vin <= 12'(code[0]);
         selAlt = altTab[t] || !fullRead;
         code[1] = selAlt ? (code[0] ^ 2048) : code[0];
         expQ.push_back(code[0]);
         expQ.push_back(code[1]);
         host.track(altTab[t]);
         repeat (6) @(negedge clk_sys);
         for (j = 0; j < 2; j++)
         begin
            check_bit("powerOn", 1'b1, pwr[j]);
            check_bit("trackEn", 1'b1, trk[j]);
            check_bit("oe", 1'b1, oe[j]);
            check_bit("dout low", 1'b0, dout[j]);
            check_bit("channel two", j == 0 && selAlt, ch2[j]);
            check_bit("bipolar", j == 1 && selAlt, bip[j]);
         end
         host.convert();
         repeat (6) @(negedge clk_sys);
         for (j = 0; j < 2; j++)
         begin
            check_bit("hold trackEn", 1'b0, trk[j]);
            check_bit("hold powerOn", 1'b1, pwr[j]);
         end
         repeat (68) @(negedge clk_sys);
         for (j = 0; j < 2; j++)
         begin
            check_bit("shutdown powerOn", 1'b0, pwr[j]);
            check_bit("msb", code[j][11], dout[j] & oe[j]);
            check_word("dacCode", 12'(code[0]), j ? dacB : dacA);
         end
         host.read(lenTab[t], w[0], w[1]);
         repeat (4) @(negedge clk_sys);
         for (j = 0; j < 2; j++)
         begin
            check_word("result", 12'(expQ.pop_front() >> (12 - lenTab[t])), w[j]);
            check_bit("oe after read", lenTab[t] < 12, oe[j]);
         end
         fullRead = (lenTab[t] >= 12);
         $display("test %0d done alt %0b bits %0d", t, altTab[t], lenTab[t]);
      end
      // reset in mid-run, then a lone selection pulse that is never followed up
      @(posedge clk_sys) resetn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (2) @(negedge clk_sys);
      for (j = 0; j < 2; j++)
      begin
         check_bit("reset powerOn", 1'b0, pwr[j]);
         check_bit("reset selection", 1'b0, ch2[j] | bip[j]);
      end
      host.pulse();
      repeat (8) @(negedge clk_sys);
      check_bit("gap powerOn", 1'b1, pwr[0] & pwr[1]);
      repeat (30) @(negedge clk_sys);
      for (j = 0; j < 2; j++)
      begin
         check_bit("abandon powerOn", 1'b0, pwr[j]);
         check_bit("abandon oe", 1'b0, oe[j]);
      end
      $display("test abandon done");
      test_done();
   end
endmodule : sar_adc_strobe_sequencer_bench
`default_nettype wire
